/* File: verilog/sbs_defines.svh */
// Purpose: Offsets, field positions, reset values and counts of the serial block
// Assumes: Included by bare name from the design module, the checker and the test; the package does not include it
// Notes: Definitions only
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SBS_OFS_CONTROL_ONE 8'h00
`define SBS_OFS_CONTROL_TWO 8'h04
`define SBS_OFS_BIT_RATE 8'h08
`define SBS_OFS_STATUS 8'h0C
`define SBS_OFS_DATA 8'h10

// ----------------------------------------
// Control one fields
// ----------------------------------------
`define SBS_C1_RX_IRQ_EN 7
`define SBS_C1_ENABLE 6
`define SBS_C1_TX_IRQ_EN 5
`define SBS_C1_MASTER 4
`define SBS_C1_CPOL 3
`define SBS_C1_CPHA 2
`define SBS_C1_SEL_OUT_EN 1
`define SBS_C1_LSB_FIRST 0

// ----------------------------------------
// Control two, bit rate and status fields
// ----------------------------------------
`define SBS_C2_FAULT_EN 4
`define SBS_C2_WRITE_MASK 8'h1B
`define SBS_BR_WRITE_MASK 8'h77
`define SBS_BR_PRESCALE_HI 6
`define SBS_BR_PRESCALE_LO 4
`define SBS_BR_RATE_HI 2
`define SBS_BR_RATE_LO 0
`define SBS_ST_RX_FULL 7
`define SBS_ST_TX_EMPTY 5
`define SBS_ST_MODE_FAULT 4

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define SBS_RST_CONTROL_ONE 8'h04
`define SBS_RST_CONTROL_TWO 8'h00
`define SBS_RST_BIT_RATE 8'h00
`define SBS_LAST_EDGE 4'hF

`endif

/* File: verilog/sbs_pkg.sv */
// Purpose: Types shared by the serial block and its bench
// Assumes: Constants are written in place; the defines header is not included
// Notes: Nothing here is imported; users write sbs_pkg::name
package sbs_pkg;

    // ----------------------------------------
    // Shifter states
    // ----------------------------------------
    typedef enum logic [0:0] {
        SBS_IDLE = 1'b0,
        SBS_SHIFT = 1'b1
    } sbs_state_e;

    // ----------------------------------------
    // Bus request and pin carriers
    // ----------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sbs_apb_req_s;

    typedef struct packed {
        logic miso;
        logic ss_n_in;
    } sbs_pin_in_s;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic mosi;
        logic mosi_oe;
        logic ss_n_out;
        logic ss_n_oe;
    } sbs_pin_out_s;

    // ----------------------------------------
    // Whole module state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] control_one;
        logic [7:0] control_two;
        logic [7:0] bit_rate;
        logic receive_full_flag;
        logic transmit_empty_flag;
        logic mode_fault_flag;
        logic rx_armed;
        logic tx_armed;
        logic fault_armed;
        logic [7:0] tx_buf;
        logic tx_full;
        logic [7:0] rx_buf;
        logic [7:0] shifter;
        logic rx_bit;
        logic [1:0] smp_pipe;
        logic [2:0] smp_cnt;
        logic [7:0] rx_sr;
        sbs_state_e state;
        logic [3:0] edge_cnt;
        logic [2:0] pre_cnt;
        logic [6:0] div_cnt;
        logic sck_phase;
        logic [1:0] miso_sync;
        logic [1:0] ss_sync;
        logic [31:0] prdata;
        logic pslverr;
    } sbs_state_s;

endpackage

/* File: verilog/sbs_serial.sv */
// Purpose: Bit-rate generator, status flags and byte shifter of a serial interface
// Assumes: APB slave on pclk; serial pins sampled through two flip-flops
// Notes: Shifting runs in master mode only; the select pin is watched only as a master-mode fault input
`timescale 1ns/1ps
`include "sbs_defines.svh"

// Functional notes
// RQ1: Prescaler divides bus clock by code plus one
// RQ2: Prescaler runs on bus clock, feeds divider
// RQ3: Divider divides by two to code plus one
// RQ4: Divider output is master serial clock
// RQ5: Bit rate register accessible at any time
// RQ6: Unused status bits read as zero
// RQ7: Status writes change nothing
// RQ8: Receive full sets when byte arrives
// RQ9: Receive full clears by status then data read
// RQ10: Transmit empty high while buffer has room
// RQ11: Transmit empty clears by status then data write
// RQ12: Data write without armed status read discarded
// RQ13: Transmit interrupt while empty and enabled
// RQ14: Transmit empty sets when byte reaches shifter
// RQ15: Idle write moves to shifter within two cycles
// RQ16: Queued byte loads shifter when shift ends
// RQ17: Empty buffer at shift end moves nothing
// RQ18: Mode fault sets on master select low
// RQ19: Fault input only with master, enable, no output
// RQ20: Mode fault clears by status read, control write
// RQ21: Disable clears receive full, sets transmit empty
// RQ22: Receive or fault interrupt when enabled
// RQ23: Reset gives empty set, others clear, disarmed
module sbs_serial (
    input wire logic pclk,
    input wire logic presetn,
    input wire sbs_pkg::sbs_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sbs_pkg::sbs_pin_in_s pin_in,
    output sbs_pkg::sbs_pin_out_s pin_out,
    output logic tx_irq,
    output logic rx_fault_irq
);

    // ----------------------------------------
    // State and decoded views
    // ----------------------------------------
    sbs_pkg::sbs_state_s st;
    sbs_pkg::sbs_state_s next_st;

    logic enabled;
    logic master;
    logic cpha;
    logic lsb_first;
    logic fault_input;
    logic [2:0] prescale_code;
    logic [2:0] rate_divider_code;
    logic [6:0] div_limit;
    logic [7:0] div_span;
    logic [7:0] status_view;
    logic setup;
    logic access;
    logic mapped;
    logic [7:0] sel_rdata;
    logic [7:0] tx_rev;
    logic [7:0] rx_word;
    logic [7:0] rx_rev;

    // Control and bit rate field views
    assign enabled = st.control_one[`SBS_C1_ENABLE];
    assign master = st.control_one[`SBS_C1_MASTER];
    assign cpha = st.control_one[`SBS_C1_CPHA];
    assign lsb_first = st.control_one[`SBS_C1_LSB_FIRST];
    assign prescale_code = st.bit_rate[`SBS_BR_PRESCALE_HI:`SBS_BR_PRESCALE_LO];
    assign rate_divider_code = st.bit_rate[`SBS_BR_RATE_HI:`SBS_BR_RATE_LO];

    // Select pin is a fault input only in this one setting
    assign fault_input = enabled && master && st.control_two[`SBS_C2_FAULT_EN]
                         && !st.control_one[`SBS_C1_SEL_OUT_EN]; // [RQ19]

    // Half period of the serial clock in prescaler ticks, less one
    assign div_span = (8'h01 << rate_divider_code) - 8'h01;
    assign div_limit = div_span[6:0];

    // ----------------------------------------
    // Receive word and bit order
    // ----------------------------------------
    // Newest synchronised bit joins the partial receive word
    assign rx_word = {st.rx_sr[6:0], st.miso_sync[1]};

    // Bit order reversal for least-significant-first transfers
    genvar g;
    for (g = 0; g < 8; g++) begin : gen_rev
        assign tx_rev[g] = st.tx_buf[7 - g];
        assign rx_rev[g] = rx_word[7 - g];
    end

    // Status byte, unused positions fixed at zero
    always_comb begin
        status_view = 8'h00; // [RQ6]
        status_view[`SBS_ST_RX_FULL] = st.receive_full_flag;
        status_view[`SBS_ST_TX_EMPTY] = st.transmit_empty_flag;
        status_view[`SBS_ST_MODE_FAULT] = st.mode_fault_flag;
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable;

    // Read data selection for the setup phase
    always_comb begin
        mapped = 1'b1;
        sel_rdata = 8'h00;
        case (apb_req.paddr)
            `SBS_OFS_CONTROL_ONE: begin
                sel_rdata = st.control_one;
            end
            `SBS_OFS_CONTROL_TWO: begin
                sel_rdata = st.control_two;
            end
            `SBS_OFS_BIT_RATE: begin
                sel_rdata = st.bit_rate; // [RQ5]
            end
            `SBS_OFS_STATUS: begin
                sel_rdata = status_view;
            end
            `SBS_OFS_DATA: begin
                sel_rdata = st.rx_buf;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic pre_tick;
        logic half_tick;
        logic do_sample;
        logic do_shift;
        logic st_read;
        logic data_read;
        logic data_write;
        logic c1_write;
        pre_tick = 1'b0;
        half_tick = 1'b0;
        do_sample = 1'b0;
        do_shift = 1'b0;
        st_read = 1'b0;
        data_read = 1'b0;
        data_write = 1'b0;
        c1_write = 1'b0;
        next_st = st;

        // Pin synchronisers
        next_st.miso_sync = {st.miso_sync[0], pin_in.miso};
        next_st.ss_sync = {st.ss_sync[0], pin_in.ss_n_in};

        // Bus side: read data latched in setup, effects at access
        if (setup) begin
            next_st.prdata = {24'h000000, sel_rdata};
            next_st.pslverr = !mapped;
        end
        st_read = access && !apb_req.pwrite && (apb_req.paddr == `SBS_OFS_STATUS);
        data_read = access && !apb_req.pwrite && (apb_req.paddr == `SBS_OFS_DATA);
        data_write = access && apb_req.pwrite && (apb_req.paddr == `SBS_OFS_DATA);
        c1_write = access && apb_req.pwrite && (apb_req.paddr == `SBS_OFS_CONTROL_ONE);

        // Register writes; status writes fall through unused
        if (access && apb_req.pwrite) begin
            case (apb_req.paddr)
                `SBS_OFS_CONTROL_ONE: begin
                    next_st.control_one = apb_req.pwdata[7:0];
                end
                `SBS_OFS_CONTROL_TWO: begin
                    next_st.control_two = apb_req.pwdata[7:0] & `SBS_C2_WRITE_MASK;
                end
                `SBS_OFS_BIT_RATE: begin
                    next_st.bit_rate = apb_req.pwdata[7:0] & `SBS_BR_WRITE_MASK; // [RQ5]
                end
                default: begin
                    next_st.control_one = st.control_one; // [RQ7]
                end
            endcase
        end

        // Arming by a status read that returned the flag set
        if (st_read && st.prdata[`SBS_ST_RX_FULL]) begin
            next_st.rx_armed = 1'b1;
        end
        if (st_read && st.prdata[`SBS_ST_TX_EMPTY]) begin
            next_st.tx_armed = 1'b1;
        end
        if (st_read && st.prdata[`SBS_ST_MODE_FAULT]) begin
            next_st.fault_armed = 1'b1;
        end

        // Receive full cleared by the armed data read
        if (data_read && st.rx_armed) begin
            next_st.receive_full_flag = 1'b0; // [RQ9]
            next_st.rx_armed = 1'b0;
        end

        // Data write queues only after the armed status read
        if (data_write && st.tx_armed && st.transmit_empty_flag) begin
            next_st.tx_buf = apb_req.pwdata[7:0];
            next_st.tx_full = 1'b1;
            next_st.transmit_empty_flag = 1'b0; // [RQ11]
            next_st.tx_armed = 1'b0;
        end else if (data_write) begin
            next_st.tx_buf = st.tx_buf; // [RQ12]
        end

        // Mode fault cleared by the armed control one write
        if (c1_write && st.fault_armed) begin
            next_st.mode_fault_flag = 1'b0; // [RQ20]
            next_st.fault_armed = 1'b0;
        end

        // Mode fault detection, wins over the clear
        if (fault_input && !st.ss_sync[1]) begin
            next_st.mode_fault_flag = 1'b1; // [RQ18]
        end

        // Prescaler and divider, running only while shifting
        if (st.state == sbs_pkg::SBS_SHIFT) begin
            if (st.pre_cnt == prescale_code) begin
                next_st.pre_cnt = 3'h0;
                pre_tick = 1'b1; // [RQ1] [RQ2]
            end else begin
                next_st.pre_cnt = st.pre_cnt + 3'h1;
            end
            if (pre_tick) begin
                if (st.div_cnt == div_limit) begin
                    next_st.div_cnt = 7'h00;
                    half_tick = 1'b1; // [RQ3]
                end else begin
                    next_st.div_cnt = st.div_cnt + 7'h01;
                end
            end
        end

        // Transfer engine
        case (st.state)
            sbs_pkg::SBS_IDLE: begin
                if (enabled && master && st.tx_full) begin
                    next_st.shifter = lsb_first ? tx_rev : st.tx_buf;
                    next_st.tx_full = 1'b0;
                    next_st.transmit_empty_flag = 1'b1; // [RQ14] [RQ15] [RQ16]
                    next_st.state = sbs_pkg::SBS_SHIFT;
                    next_st.edge_cnt = 4'h0;
                    next_st.pre_cnt = 3'h0;
                    next_st.div_cnt = 7'h00;
                    next_st.sck_phase = 1'b0;
                end
            end
            sbs_pkg::SBS_SHIFT: begin
                if (half_tick) begin
                    next_st.sck_phase = !st.sck_phase; // [RQ4]
                    next_st.edge_cnt = st.edge_cnt + 4'h1;
                    do_sample = (st.edge_cnt[0] == cpha);
                    do_shift = !do_sample && (st.edge_cnt != 4'h0) && (st.edge_cnt != `SBS_LAST_EDGE);
                    if (do_sample) begin
                        next_st.rx_bit = st.miso_sync[1];
                    end
                    if (do_shift) begin
                        next_st.shifter = {st.shifter[6:0], st.rx_bit};
                    end
                    // Frame ends; select rises a cycle, queued byte loads from idle
                    if (st.edge_cnt == `SBS_LAST_EDGE) begin
                        next_st.sck_phase = 1'b0;
                        next_st.state = sbs_pkg::SBS_IDLE; // [RQ17]
                    end
                end
            end
            default: begin
                next_st.state = sbs_pkg::SBS_IDLE;
            end
        endcase

        // Capture two cycles after the sample edge, matching the pin synchroniser
        next_st.smp_pipe = {st.smp_pipe[0], do_sample};
        if (st.smp_pipe[1]) begin
            next_st.rx_sr = rx_word;
            next_st.smp_cnt = st.smp_cnt + 3'h1;
            if (st.smp_cnt == 3'h7) begin
                // Overrun keeps the older byte
                if (!st.receive_full_flag) begin
                    next_st.rx_buf = lsb_first ? rx_rev : rx_word;
                end
                next_st.receive_full_flag = 1'b1; // [RQ8]
            end
        end

        // Disabled interface holds everything empty
        if (!enabled) begin
            next_st.receive_full_flag = 1'b0; // [RQ21]
            next_st.transmit_empty_flag = 1'b1; // [RQ21] [RQ10]
            next_st.tx_full = 1'b0;
            next_st.rx_armed = 1'b0;
            next_st.tx_armed = 1'b0;
            next_st.state = sbs_pkg::SBS_IDLE;
            next_st.sck_phase = 1'b0;
            next_st.edge_cnt = 4'h0;
            next_st.smp_pipe = 2'h0;
            next_st.smp_cnt = 3'h0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.control_one <= `SBS_RST_CONTROL_ONE;
            st.control_two <= `SBS_RST_CONTROL_TWO;
            st.bit_rate <= `SBS_RST_BIT_RATE;
            st.transmit_empty_flag <= 1'b1; // [RQ23]
            st.miso_sync <= 2'h0;
            st.ss_sync <= 2'h3;
            st.state <= sbs_pkg::SBS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Bus answers in the first access cycle
    assign pready = 1'b1;
    assign prdata = st.prdata;
    assign pslverr = st.pslverr;

    // Interrupt requests
    assign tx_irq = st.transmit_empty_flag && st.control_one[`SBS_C1_TX_IRQ_EN]; // [RQ13]
    assign rx_fault_irq = (st.receive_full_flag || st.mode_fault_flag)
                          && st.control_one[`SBS_C1_RX_IRQ_EN]; // [RQ22]

    // Serial pins
    always_comb begin
        pin_out.sck = st.control_one[`SBS_C1_CPOL] ^ st.sck_phase; // [RQ4]
        pin_out.sck_oe = enabled && master;
        pin_out.mosi = st.shifter[7];
        pin_out.mosi_oe = enabled && master;
        pin_out.ss_n_out = !(st.state == sbs_pkg::SBS_SHIFT);
        pin_out.ss_n_oe = enabled && master && st.control_two[`SBS_C2_FAULT_EN]
                          && st.control_one[`SBS_C1_SEL_OUT_EN];
    end

endmodule

/* File: sim/sbs_serial_props.sv */
// Purpose: Port-level checks of the serial block
// Assumes: Bound to sbs_serial; one clock domain
// Notes: Sees the top ports only
`timescale 1ns/1ps
`include "sbs_defines.svh"
module sbs_serial_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire sbs_pkg::sbs_apb_req_s apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire sbs_pkg::sbs_pin_in_s pin_in,
    input wire sbs_pkg::sbs_pin_out_s pin_out,
    input wire logic tx_irq,
    input wire logic rx_fault_irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic acc;
    logic rd_st;
    logic sck_q;
    logic [4:0] edge_cnt;
    assign acc = apb_req.psel && apb_req.penable;
    assign rd_st = acc && !apb_req.pwrite && apb_req.paddr == `SBS_OFS_STATUS;
    // Serial clock edges within one frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q <= 1'b0;
            edge_cnt <= 5'h00;
        end else begin
            sck_q <= pin_out.sck;
            if (pin_out.ss_n_out) begin
                edge_cnt <= 5'h00;
            end else if (pin_out.sck != sck_q) begin
                edge_cnt <= edge_cnt + 5'h01;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_BR_ANY_TIME: assert property (acc && apb_req.paddr == `SBS_OFS_BIT_RATE |-> pready && !pslverr)
        else $error("bit rate access refused");
    AST_STATUS_ZERO: assert property (rd_st |-> prdata[31:8] == 24'h0 && !prdata[6] && prdata[3:0] == 4'h0)
        else $error("unused status bits not zero");
    AST_TX_IRQ_FLAG: assert property (rd_st && $past(tx_irq) |-> prdata[5])
        else $error("transmit request without empty flag");
    AST_RX_IRQ_FLAG: assert property (rd_st && $past(rx_fault_irq) |-> prdata[7] || prdata[4])
        else $error("receive request without flag");
    AST_OE_PAIR: assert property (pin_out.sck_oe == pin_out.mosi_oe)
        else $error("clock and data enables differ");
    AST_SS_OE: assert property (pin_out.ss_n_oe |-> pin_out.sck_oe)
        else $error("select driven outside master mode");
    AST_SCK_IDLE: assert property (pin_out.ss_n_out && $past(pin_out.ss_n_out) && !$past(acc && apb_req.pwrite)
        |-> $stable(pin_out.sck))
        else $error("serial clock moved between frames");
    AST_EDGE_COUNT: assert property ($rose(pin_out.ss_n_out) |-> edge_cnt + 5'(pin_out.sck != sck_q) == 5'h10)
        else $error("frame edge count not sixteen");
    AST_FRAME_MIN: assert property ($fell(pin_out.ss_n_out) |-> !pin_out.ss_n_out [*8])
        else $error("frame shorter than minimum");
    // Main scenarios
    CV_FRAME: cover property ($rose(pin_out.ss_n_out));
    CV_FAULT: cover property (rd_st && prdata[4]);
    CV_TX_IRQ: cover property ($rose(tx_irq));
    CV_UNMAPPED: cover property (acc && pslverr);
endmodule

/* File: sim/sbs_slave_model.sv */
// Purpose: Far-side slave on the serial pins
// Assumes: Clock idles low, data changes on rising clock
// Notes: Sends reply MSB first; pull_low pulls the select pin low only while ss_n_oe is low
`timescale 1ns/1ps
module sbs_slave_model (
    input wire sbs_pkg::sbs_pin_out_s pin_out,
    input wire logic pull_low,
    input wire logic [7:0] reply,
    output sbs_pkg::sbs_pin_in_s pin_in
);
    logic [2:0] idx = 3'h0;
    logic last = 1'b0;
    // Frame start and bit output
    always @(negedge pin_out.ss_n_out) idx = 3'h0;
    always @(posedge pin_out.sck) begin
        if (!pin_out.ss_n_out) begin
            last = reply[3'h7 - idx];
            idx = idx + 3'h1;
        end
    end
    // Released line shows inverse; select pin has a pull-up
    assign pin_in.miso = pin_out.ss_n_out ? ~last : last;
    assign pin_in.ss_n_in = pin_out.ss_n_oe ? pin_out.ss_n_out : !pull_low;
endmodule

/* File: sim/test_spi_baud_and_status_flags.sv */
// Purpose: Register-level tests of the serial block
// Assumes: One-cycle APB answer; slave model on the pins
// Notes: Sweeps all divider codes
`timescale 1ns/1ps
`include "sbs_defines.svh"
module test_spi_baud_and_status_flags;
    localparam logic [7:0] a_c1 = `SBS_OFS_CONTROL_ONE;
    localparam logic [7:0] a_br = `SBS_OFS_BIT_RATE;
    localparam logic [7:0] a_st = `SBS_OFS_STATUS;
    localparam logic [7:0] a_dat = `SBS_OFS_DATA;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    sbs_pkg::sbs_apb_req_s apb_req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_irq, rx_fault_irq, last_err;
    sbs_pkg::sbs_pin_in_s pin_in;
    sbs_pkg::sbs_pin_out_s pin_out;
    logic pull_low = 1'b0;
    logic [7:0] reply = 8'hB4;
    logic [31:0] rd;
    logic [7:0] br;
    int bad_count = 0;
    int tests_run = 0;
    int frames = 0;
    int f0, n;
    always #5 pclk = ~pclk;
    always @(posedge pin_out.ss_n_out) if (presetn) frames++;
    sbs_serial u_sbs_serial (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .tx_irq(tx_irq),
        .rx_fault_irq(rx_fault_irq));
    sbs_slave_model u_sbs_slave_model (.pin_out(pin_out), .pull_low(pull_low), .reply(reply), .pin_in(pin_in));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task end_sim;
        $display("counts: %0d compared, %0d bad", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        last_err = pslverr;
        apb_req <= '0;
        if (k >= 50) chk(32'h0, 32'h1, "no ready");
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read");
    endtask
    task send(input logic [7:0] b);
        apb(1'b0, a_st, 32'h0);
        chk(rd[5], 32'h1, "empty before write");
        apb(1'b1, a_dat, {24'h0, b});
    endtask
    task wait_rx;
        int k;
        k = 0;
        do begin
            apb(1'b0, a_st, 32'h0);
            k++;
        end while (rd[7] !== 1'b1 && k < 2000);
        chk(rd[7], 32'h1, "receive full");
    endtask
    task measure(input int half);
        logic s;
        @(negedge pclk);
        s = pin_out.sck;
        n = 0;
        while (pin_out.sck === s && n < 5000) begin @(negedge pclk); n++; end
        s = pin_out.sck;
        n = 0;
        while (pin_out.sck === s && n < 5000) begin @(negedge pclk); n++; end
        chk(n, half, "half period");
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(a_st, 32'h20);
        rdc(a_br, 32'h0);
        rdc(a_c1, 32'h04);
        apb(1'b0, 8'h14, 32'h0);
        chk(last_err, 32'h1, "unmapped");
        apb(1'b1, a_br, 32'hFF);
        rdc(a_br, 32'h77);
        apb(1'b1, a_st, 32'hFF);
        rdc(a_st, 32'h20);
        $display("test registers done");
        apb(1'b1, a_c1, 32'h54);
        for (int i = 0; i < 16; i++) begin
            br = (i < 8) ? {1'b0, i[2:0], 4'h0} : {5'h0, i[2:0]};
            apb(1'b1, a_br, {24'h0, br});
            send(8'h5A);
            measure((i < 8) ? i + 1 : 1 << (i - 8));
            wait_rx;
            rdc(a_dat, {24'h0, reply});
            rdc(a_st, 32'h20);
        end
        $display("test divider sweep done");
        apb(1'b1, a_br, 32'h02);
        apb(1'b1, a_c1, 32'h74);
        @(negedge pclk);
        chk(tx_irq, 32'h1, "idle irq");
        f0 = frames;
        send(8'h3C);
        apb(1'b1, a_dat, 32'h11);
        rdc(a_st, 32'h20);
        send(8'hC3);
        rdc(a_st, 32'h00);
        @(negedge pclk);
        chk(tx_irq, 32'h0, "full irq");
        n = 0;
        while (tx_irq !== 1'b1 && n < 500) begin @(negedge pclk); n++; end
        chk(tx_irq, 32'h1, "queued byte moved");
        n = 0;
        while (frames < f0 + 2 && n < 1000) begin @(negedge pclk); n++; end
        repeat (100) @(posedge pclk);
        chk(frames, f0 + 2, "frame count");
        rdc(a_st, 32'hA0);
        rdc(a_dat, {24'h0, reply});
        $display("test queue done");
        apb(1'b1, `SBS_OFS_CONTROL_TWO, 32'h10);
        apb(1'b1, a_c1, 32'hD4);
        pull_low <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(rx_fault_irq, 32'h1, "fault irq");
        pull_low <= 1'b0;
        apb(1'b1, a_c1, 32'hD4);
        rdc(a_st, 32'h30);
        apb(1'b1, a_c1, 32'hD4);
        rdc(a_st, 32'h20);
        @(negedge pclk);
        chk(rx_fault_irq, 32'h0, "fault cleared");
        apb(1'b1, `SBS_OFS_CONTROL_TWO, 32'h00);
        pull_low <= 1'b1;
        repeat (4) @(posedge pclk);
        rdc(a_st, 32'h20);
        pull_low <= 1'b0;
        $display("test fault done");
        apb(1'b1, a_c1, 32'h54);
        send(8'h77);
        wait_rx;
        apb(1'b1, a_c1, 32'h14);
        rdc(a_st, 32'h20);
        $display("test disable done");
        end_sim;
    end
    // Hang guard
    initial begin
        #500000;
        bad_count++;
        $display("unexpected at %0t: timeout", $time);
        end_sim;
    end
endmodule
bind sbs_serial sbs_serial_props u_sbs_serial_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .tx_irq(tx_irq),
    .rx_fault_irq(rx_fault_irq));
